/* File: inc/pwr_seq_defines.vh */
`ifndef PWR_SEQ_DEFINES_VH
`define PWR_SEQ_DEFINES_VH
// register addresses
`define ADDR_FULL_POWER_CONFIG   7'h53
`define ADDR_SLEEP_POWER_CONFIG  7'h64
`define ADDR_POWERDOWN_COMMAND   7'h65
`define ADDR_DISC_COUNT          7'h5F
`define ADDR_WAKE_IRQ_ENABLE     7'h40
// field positions
`define FP_CUR_ADC_BIT     0
`define FP_VT_ADC_BIT      1
`define FP_BIAS10_BIT      3
`define FP_BIAS5_BIT       4
`define FP_REFBUF_BIT      5
`define FP_RW_MASK         8'h3B
`define SP_STATE_LSB       0
`define SP_MEAS_LSB        2
`define IRQ_WDOG_BIT       0
`define IRQ_SLEEPT_BIT     1
`define IRQ_CUR_BIT        2
`define IRQ_VT_BIT         3
`define IRQ_LIN_BIT        4
// reset values and the enter power-down command code
`define FULL_POWER_RESET   8'h00
`define SLEEP_POWER_RESET  8'h20
`define CMD_RESET          8'h00
`define CMD_ENTER_PD       8'hA9
// measurement modes
`define MEAS_DISC_EXT      3'h3
`define MEAS_CONT_I        3'h4
`define MEAS_CONT_IV       3'h5
`define MEAS_CONT_ITI      3'h6
`define MEAS_CONT_ITE      3'h7
// power-down state selector
`define SEL_ULP            2'h2
`define SEL_OFF            2'h3
// timing
`define CLK_MHZ            100
`define LIN_WAKE_US        150
`define LIN_WAKE_CYC       (`LIN_WAKE_US * `CLK_MHZ)
`define SETTLE_CYC         16
`endif

/* File: rtl/pin_sync3.v */
`timescale 1ns/1ns
// three-stage synchroniser; output moves when stages two and three agree
module pin_sync3 (
    input  wire ref_clk,  // system clock
    input  wire rstn,     // async reset, active low
    input  wire pin_in,   // asynchronous input
    output reg  pin_out   // filtered level
);
    reg [2:0] sh_ff;

    // stage 0 only feeds stage 1
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sh_ff   <= 3'h7;
            pin_out <= 1'b1;
        end else begin
            sh_ff <= {sh_ff[1:0], pin_in};
            if (sh_ff[1] == sh_ff[2]) begin
                pin_out <= sh_ff[2];
            end
        end
    end
endmodule // pin_sync3

/* File: rtl/spi_reg_slave.v */
`timescale 1ns/1ns
// spi mode 0 register slave: byte0 = {rw, addr[6:0]}, byte1 = data
// writes issue a one-cycle strobe after the data byte; csn rising is flagged
module spi_reg_slave (
    input  wire       ref_clk,   // system clock
    input  wire       rstn,      // async reset, active low
    input  wire       sclk,      // spi clock, synchronised
    input  wire       csn,       // chip select, synchronised
    input  wire       mosi,      // serial in, synchronised
    output reg        miso,      // serial out
    output reg        wr_stb,    // write strobe pulse
    output reg  [6:0] addr,      // register address
    output reg  [7:0] wdata,     // write data
    input  wire [7:0] rdata,     // read data for addr
    output reg        cs_rise    // chip select released pulse
);
    reg       sclk_d_ff;
    reg       csn_d_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] sh_ff;
    reg       rd_ff;
    reg [7:0] tx_ff;

    // sample on rising, shift out on falling sclk
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d_ff  <= 1'b0;
            csn_d_ff   <= 1'b1;
            bit_cnt_ff <= 4'h0;
            sh_ff      <= 8'h00;
            rd_ff      <= 1'b0;
            tx_ff      <= 8'h00;
            miso       <= 1'b0;
            wr_stb     <= 1'b0;
            addr       <= 7'h00;
            wdata      <= 8'h00;
            cs_rise    <= 1'b0;
        end else begin
            sclk_d_ff <= sclk;
            csn_d_ff  <= csn;
            wr_stb    <= 1'b0;
            cs_rise   <= csn & ~csn_d_ff;
            if (csn) begin
                bit_cnt_ff <= 4'h0;
            end else if (sclk & ~sclk_d_ff) begin
                sh_ff      <= {sh_ff[6:0], mosi};
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                if (bit_cnt_ff == 4'h7) begin
                    rd_ff <= sh_ff[6];
                    addr  <= {sh_ff[5:0], mosi};
                end
                if (bit_cnt_ff == 4'hF && !rd_ff) begin
                    wdata  <= {sh_ff[6:0], mosi};
                    wr_stb <= 1'b1;
                end
            end else if (~sclk & sclk_d_ff) begin
                // read data loaded once the address byte is complete
                if (bit_cnt_ff == 4'h8) begin
                    miso  <= rdata[7];
                    tx_ff <= {rdata[6:0], 1'b0};
                end else begin
                    miso  <= tx_ff[7];
                    tx_ff <= {tx_ff[6:0], 1'b0};
                end
            end
        end
    end
endmodule // spi_reg_slave

/* File: rtl/power_down_measurement_sequencer.v */
// Behaviour
// - mode 3 runs discrete current, voltage, external temperature sequence.
// - mode 4 keeps current ADC on, voltage/temperature ADC off.
// - continuous modes power ADCs on entry, trigger timer stays off.
// - mode 5 keeps both ADCs on, current and voltage continuous.
// - mode 6 like 5, second ADC measures internal temperature.
// - mode 7 like 6, second ADC measures external temperature.
// - continuous wake sources: watchdog, sleep timer, LIN, current; plus mode extras.
// - no enabled wake source means staying powered down.
// - enable bit 0 watchdog, bit 1 sleep timer, bit 4 LIN wake.
// - state selector 0/1 low-power, 2 ultra-low, 3 off.
// - command A9 then chip select high enters power-down.
// - wake restores full power, then clock; reset after ultra-low releases in the same cycle as the clock.
// - enabled wake during a measurement aborts it.
// - off state stops clocks, unpowers controller, only core and LIN rx.
// - off state wakes only on LIN frame when enabled.
// - LIN low at least 150 us in off wakes fully.
// - LIN high again earlier stops oscillator, stays off.
// - full power bit 0 current ADC, bit 1 voltage ADC, reset 0.
// - bits 3 and 4 cut bias; both cut combined.
// - bit 5 refbuf offset cancel off; bit 2 reserved, bits 7:6 read zero.
// - measurement mode in bits 4:2 of sleep configuration.
// - command register write-only, reset zero, only A9 arms.
`timescale 1ns/1ns
`include "pwr_seq_defines.vh"
module power_down_measurement_sequencer #(
    parameter LIN_WAKE_CYC = `LIN_WAKE_CYC,  // off-state LIN low time in cycles
    parameter SETTLE_CYC   = `SETTLE_CYC     // block stabilisation time
) (
    input  wire       ref_clk,          // 100 MHz clock
    input  wire       rstn,             // async reset, active low
    input  wire       spi_sclk,         // spi clock pin
    input  wire       spi_csn,          // spi chip select pin, active low
    input  wire       spi_mosi,         // spi data in
    output wire       spi_miso,         // spi data out
    input  wire       lin_rxd,          // LIN receive line
    input  wire       wdog_irq,         // watchdog interrupt level
    input  wire       sleep_timer_irq,  // sleep timer interrupt level
    input  wire       cur_adc_irq,      // current ADC interrupt level
    input  wire       volt_adc_irq,     // voltage ADC interrupt level
    input  wire       temp_adc_irq,     // temperature ADC interrupt level
    input  wire       meas_busy,        // discrete measurement running
    output reg        current_adc_power,   // current ADC supply enable
    output reg        volt_temp_adc_power, // voltage/temperature ADC supply enable
    output reg        temp_ext_sel,     // second ADC samples external sensor
    output reg        vt_meas_temp,     // second ADC measures temperature
    output reg        trig_timer_en,    // discrete trigger timer enable
    output reg        meas_abort,       // abort measurement pulse
    output reg  [1:0] bias_cut,         // {five pct, ten pct} bias reduction
    output reg        refbuf_offcancel_off, // refbuf offset cancel off
    output reg        lp_osc_en,        // low-power oscillator enable
    output reg        hp_clk_en,        // full-power clocks enable
    output reg        mcu_supply_en,    // controller supply
    output reg        mcu_clk_en,       // controller clock output enable
    output reg        mcu_rst_n,        // controller reset, active low
    output reg        analog_pd,        // most analog blocks powered down
    output reg  [1:0] pwr_state         // 0 full, 1 low, 2 ultra-low, 3 off
);
    localparam ST_FP     = 3'h0;
    localparam ST_SLEEP  = 3'h1;
    localparam ST_OFF    = 3'h2;
    localparam ST_LINCHK = 3'h3;
    localparam ST_SETTLE = 3'h4;

    wire       sclk_s;
    wire       csn_s;
    wire       mosi_s;
    wire       lin_s;
    wire       wr_stb;
    wire [6:0] addr;
    wire [7:0] wdata;
    wire       cs_rise;
    reg  [7:0] rdata;

    reg  [7:0]  full_power_config_ff;
    reg  [7:0]  sleep_power_config_ff;
    reg  [7:0]  wake_irq_enable_ff;
    reg  [7:0]  disc_count_ff;
    reg         armed_ff;
    reg  [2:0]  st_ff;
    reg  [1:0]  sel_ff;
    reg  [2:0]  mode_ff;
    reg  [31:0] cnt_ff;
    reg         wake;

    wire [1:0] sleep_state_sel = sleep_power_config_ff[`SP_STATE_LSB +: 2];
    wire [2:0] meas_mode_sel   = sleep_power_config_ff[`SP_MEAS_LSB +: 3];

    // continuous modes sit at 4..7
    function is_cont;
        input [2:0] m;
        begin
            is_cont = m[2];
        end
    endfunction

    pin_sync3 u_sclk (.ref_clk(ref_clk), .rstn(rstn), .pin_in(spi_sclk), .pin_out(sclk_s));
    pin_sync3 u_csn  (.ref_clk(ref_clk), .rstn(rstn), .pin_in(spi_csn),  .pin_out(csn_s));
    pin_sync3 u_mosi (.ref_clk(ref_clk), .rstn(rstn), .pin_in(spi_mosi), .pin_out(mosi_s));
    pin_sync3 u_lin  (.ref_clk(ref_clk), .rstn(rstn), .pin_in(lin_rxd),  .pin_out(lin_s));

    spi_reg_slave u_spi (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .sclk    (sclk_s),
        .csn     (csn_s),
        .mosi    (mosi_s),
        .miso    (spi_miso),
        .wr_stb  (wr_stb),
        .addr    (addr),
        .wdata   (wdata),
        .rdata   (rdata),
        .cs_rise (cs_rise)
    );

    // read mux; command register is write-only and reads zero
    always @* begin
        case (addr)
            `ADDR_FULL_POWER_CONFIG:  rdata = full_power_config_ff & `FP_RW_MASK | 
                                              (full_power_config_ff & 8'h04);
            `ADDR_SLEEP_POWER_CONFIG: rdata = sleep_power_config_ff;
            `ADDR_WAKE_IRQ_ENABLE:    rdata = wake_irq_enable_ff;
            `ADDR_DISC_COUNT:         rdata = disc_count_ff;
            default:                  rdata = 8'h00;
        endcase
    end

    // enabled wake sources depend on the latched mode
    always @* begin
        wake = (wake_irq_enable_ff[`IRQ_WDOG_BIT] & wdog_irq) |
               (wake_irq_enable_ff[`IRQ_SLEEPT_BIT] & sleep_timer_irq) |
               (wake_irq_enable_ff[`IRQ_CUR_BIT] & cur_adc_irq);
        if (mode_ff == `MEAS_CONT_IV) begin
            wake = wake | (wake_irq_enable_ff[`IRQ_VT_BIT] & volt_adc_irq);
        end else if (mode_ff[2:1] == 2'b11 || !is_cont(mode_ff)) begin
            wake = wake | (wake_irq_enable_ff[`IRQ_VT_BIT] & temp_adc_irq);
        end
        // LIN low is a wake frame in low-power states too
        wake = wake | (wake_irq_enable_ff[`IRQ_LIN_BIT] & ~lin_s);
    end

    // register writes and command arming
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            full_power_config_ff  <= `FULL_POWER_RESET;
            sleep_power_config_ff <= `SLEEP_POWER_RESET;
            wake_irq_enable_ff    <= 8'h00;
            disc_count_ff         <= 8'h00;
            armed_ff              <= 1'b0;
        end else begin
            if (wr_stb) begin
                case (addr)
                    `ADDR_FULL_POWER_CONFIG:  full_power_config_ff <= wdata & 8'h3F;
                    `ADDR_SLEEP_POWER_CONFIG: sleep_power_config_ff <= wdata;
                    `ADDR_WAKE_IRQ_ENABLE:    wake_irq_enable_ff <= wdata;
                    `ADDR_DISC_COUNT:         disc_count_ff <= wdata;
                    `ADDR_POWERDOWN_COMMAND:  armed_ff <= (wdata == `CMD_ENTER_PD);
                    default: ;
                endcase
            end else if (cs_rise) begin
                armed_ff <= 1'b0; // one shot per chip-select frame
            end
        end
    end

    // power sequencer
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff   <= ST_FP;
            sel_ff  <= 2'h0;
            mode_ff <= 3'h0;
            cnt_ff  <= 32'h0;
        end else begin
            case (st_ff)
                ST_FP: begin
                    cnt_ff <= 32'h0;
                    if (cs_rise && armed_ff) begin
                        sel_ff  <= sleep_state_sel;
                        mode_ff <= meas_mode_sel;
                        if (sleep_state_sel == `SEL_OFF) begin
                            st_ff <= ST_OFF;
                        end else begin
                            st_ff <= ST_SLEEP;
                        end
                    end
                end
                ST_SLEEP: begin
                    // without an enabled source nothing leaves this state
                    if (wake) begin
                        st_ff  <= ST_SETTLE;
                        cnt_ff <= 32'h0;
                    end
                end
                ST_OFF: begin
                    cnt_ff <= 32'h0;
                    if (wake_irq_enable_ff[`IRQ_LIN_BIT] && !lin_s) begin
                        st_ff <= ST_LINCHK;
                    end
                end
                ST_LINCHK: begin
                    if (lin_s) begin
                        st_ff <= ST_OFF;
                    end else if (cnt_ff >= LIN_WAKE_CYC - 2) begin
                        st_ff  <= ST_SETTLE;
                        cnt_ff <= 32'h0;
                    end else begin
                        cnt_ff <= cnt_ff + 32'h1;
                    end
                end
                ST_SETTLE: begin
                    if (cnt_ff >= SETTLE_CYC - 1) begin
                        st_ff   <= ST_FP;
                        mode_ff <= 3'h0;
                    end else begin
                        cnt_ff <= cnt_ff + 32'h1;
                    end
                end
                default: st_ff <= ST_FP;
            endcase
        end
    end

    // outputs from flip-flops, decoded from current state of the sequencer
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            current_adc_power    <= 1'b0;
            volt_temp_adc_power  <= 1'b0;
            temp_ext_sel         <= 1'b0;
            vt_meas_temp         <= 1'b0;
            trig_timer_en        <= 1'b0;
            meas_abort           <= 1'b0;
            bias_cut             <= 2'h0;
            refbuf_offcancel_off <= 1'b0;
            lp_osc_en            <= 1'b1;
            hp_clk_en            <= 1'b1;
            mcu_supply_en        <= 1'b1;
            mcu_clk_en           <= 1'b1;
            mcu_rst_n            <= 1'b1;
            analog_pd            <= 1'b0;
            pwr_state            <= 2'h0;
        end else begin
            meas_abort <= (st_ff == ST_SLEEP) & wake & meas_busy;
            case (st_ff)
                ST_FP: begin
                    current_adc_power    <= full_power_config_ff[`FP_CUR_ADC_BIT];
                    volt_temp_adc_power  <= full_power_config_ff[`FP_VT_ADC_BIT];
                    bias_cut             <= {full_power_config_ff[`FP_BIAS5_BIT],
                                             full_power_config_ff[`FP_BIAS10_BIT]};
                    refbuf_offcancel_off <= full_power_config_ff[`FP_REFBUF_BIT];
                    trig_timer_en        <= 1'b0;
                    temp_ext_sel         <= 1'b0;
                    vt_meas_temp         <= 1'b0;
                    lp_osc_en            <= 1'b1;
                    hp_clk_en            <= 1'b1;
                    mcu_supply_en        <= 1'b1;
                    mcu_clk_en           <= 1'b1;
                    mcu_rst_n            <= 1'b1;
                    analog_pd            <= 1'b0;
                    pwr_state            <= 2'h0;
                end
                ST_SLEEP: begin
                    // continuous modes hold ADCs up; discrete ones leave power to the timer
                    current_adc_power    <= is_cont(mode_ff);
                    volt_temp_adc_power  <= is_cont(mode_ff) & (mode_ff != `MEAS_CONT_I);
                    trig_timer_en        <= ~is_cont(mode_ff) & (mode_ff != 3'h0);
                    vt_meas_temp         <= (mode_ff[2:1] == 2'b11) | ~is_cont(mode_ff);
                    temp_ext_sel         <= (mode_ff == `MEAS_CONT_ITE) |
                                            (mode_ff == `MEAS_DISC_EXT);
                    bias_cut             <= sleep_power_config_ff[6:5];
                    refbuf_offcancel_off <= ~sleep_power_config_ff[7];
                    lp_osc_en            <= 1'b1;
                    hp_clk_en            <= 1'b0;
                    mcu_clk_en           <= 1'b0;
                    mcu_rst_n            <= (sel_ff != `SEL_ULP);
                    analog_pd            <= 1'b0;
                    pwr_state            <= (sel_ff == `SEL_ULP) ? 2'h2 : 2'h1;
                end
                ST_OFF, ST_LINCHK: begin
                    current_adc_power    <= 1'b0;
                    volt_temp_adc_power  <= 1'b0;
                    trig_timer_en        <= 1'b0;
                    lp_osc_en            <= (st_ff == ST_LINCHK) |
                                            (wake_irq_enable_ff[`IRQ_LIN_BIT] & ~lin_s);
                    hp_clk_en            <= 1'b0;
                    mcu_supply_en        <= 1'b0;
                    mcu_clk_en           <= 1'b0;
                    mcu_rst_n            <= 1'b0;
                    analog_pd            <= 1'b1;
                    pwr_state            <= 2'h3;
                end
                ST_SETTLE: begin
                    // full-power ADC enables back first; bias, refbuf and controller clock/reset once stable
                    current_adc_power    <= full_power_config_ff[`FP_CUR_ADC_BIT];
                    volt_temp_adc_power  <= full_power_config_ff[`FP_VT_ADC_BIT];
                    trig_timer_en        <= 1'b0;
                    lp_osc_en            <= 1'b1;
                    hp_clk_en            <= 1'b1;
                    mcu_supply_en        <= 1'b1;
                    analog_pd            <= 1'b0;
                    mcu_clk_en           <= 1'b0;
                    pwr_state            <= 2'h0;
                end
                default: pwr_state <= 2'h0;
            endcase
        end
    end
endmodule // power_down_measurement_sequencer

/* File: tb/pds_assertions.sv */
`timescale 1ns/1ns
// power state sequencing as seen at the block's pins
module pds_assertions #(
    parameter LIN_WAKE_CYC = 50 // off-state LIN low time
) (
    input wire       ref_clk,       // clock
    input wire       rstn,          // reset, active low
    input wire       lin_rxd,       // LIN line
    input wire       meas_busy,     // measurement running
    input wire       meas_abort,    // abort pulse
    input wire       lp_osc_en,     // low-power oscillator
    input wire       hp_clk_en,     // full-power clocks
    input wire       mcu_supply_en, // controller supply
    input wire       mcu_clk_en,    // controller clock
    input wire       analog_pd,     // analog blocks off
    input wire [1:0] pwr_state      // power state
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // raw LIN low run; the block's own count lags it by the synchroniser
    logic [15:0] lo_cnt_ff;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) lo_cnt_ff <= 16'h0000;
        else if (lin_rxd) lo_cnt_ff <= 16'h0000;
        else if (lo_cnt_ff != 16'hFFFF) lo_cnt_ff <= lo_cnt_ff + 16'h0001;
    end
    a_off_quiet: assert property (
        pwr_state == 2'h3 && $past(pwr_state) == 2'h3 && !lp_osc_en |-> !hp_clk_en
        && !mcu_supply_en && !mcu_clk_en && analog_pd) else $error("off state not quiet");
    a_osc_stops: assert property (
        (pwr_state == 2'h3 && lin_rxd) [*8] |-> !lp_osc_en) else $error("oscillator left on");
    a_lin_low_time: assert property (
        pwr_state == 2'h3 && lo_cnt_ff < LIN_WAKE_CYC |=> pwr_state == 2'h3)
        else $error("left off state too early");
    a_off_exit_fp: assert property (
        pwr_state == 2'h3 |=> pwr_state == 2'h3 || pwr_state == 2'h0)
        else $error("off state left to a sleep state");
    a_sleep_noclk: assert property (
        pwr_state != 2'h0 && $past(pwr_state) != 2'h0 |-> !mcu_clk_en)
        else $error("controller clock during sleep");
    a_clk_after_wake: assert property (
        $rose(mcu_clk_en) |-> pwr_state == 2'h0 && hp_clk_en && mcu_supply_en)
        else $error("controller clock before full power");
    a_abort_cause: assert property (
        meas_abort |-> $past(meas_busy)) else $error("abort without measurement");
    a_abort_pulse: assert property (
        meas_abort |=> !meas_abort) else $error("abort longer than one cycle");
endmodule // pds_assertions

bind power_down_measurement_sequencer pds_assertions #(.LIN_WAKE_CYC(LIN_WAKE_CYC)) u_chk (
    .ref_clk, .rstn, .lin_rxd, .meas_busy, .meas_abort, .lp_osc_en, .hp_clk_en,
    .mcu_supply_en, .mcu_clk_en, .analog_pd, .pwr_state);

/* File: tb/mcu_spi_model.sv */
`timescale 1ns/1ns
// spi mode 0 master standing in for the external controller
module mcu_spi_model (
    input  wire ref_clk,  // bench clock paces the bits
    input  wire spi_miso, // data from the block
    output reg  spi_sclk, // parked low between frames
    output reg  spi_csn,  // chip select, active low
    output reg  spi_mosi  // data to the block
);
    // idle bus at time zero
    initial begin
        spi_sclk = 1'b0;
        spi_csn  = 1'b1;
        spi_mosi = 1'b1;
    end
    // 16-bit frame at an 80 ns sclk; miso sampled late in the high phase
    task automatic xfer(input logic [15:0] w, output logic [7:0] q);
        @(negedge ref_clk);
        spi_csn = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = w[i];
            repeat (4) @(negedge ref_clk);
            spi_sclk = 1'b1;
            repeat (4) @(negedge ref_clk);
            if (i < 8) q = {q[6:0], spi_miso};
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        spi_csn  = 1'b1;
        spi_mosi = ~spi_mosi; // released line shows no stale bit
        repeat (8) @(negedge ref_clk);
    endtask
endmodule // mcu_spi_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`include "pwr_seq_defines.vh"
module tb_top;
    localparam int LWC = 50; // short LIN wake time keeps the run brief
    localparam int STL = 16; // settle time
    logic       ref_clk   = 1'b0;
    logic       rstn      = 1'b0;
    logic       lin_rxd   = 1'b1;
    logic       meas_busy = 1'b0;
    logic [4:0] irq       = 5'h00; // {temp, volt, cur, sleep timer, wdog}
    logic [7:0] q;
    int         failures  = 0;
    int         compares  = 0;
    int         cyc       = 0;
    wire        spi_sclk, spi_csn, spi_mosi, spi_miso, current_adc_power, volt_temp_adc_power;
    wire        temp_ext_sel, vt_meas_temp, trig_timer_en, meas_abort, refbuf_offcancel_off;
    wire        lp_osc_en, hp_clk_en, mcu_supply_en, mcu_clk_en, mcu_rst_n, analog_pd;
    wire [1:0]  bias_cut, pwr_state;
    // pins grouped so that one compare judges a whole set
    wire [7:0]  fp_pins = {2'h0, refbuf_offcancel_off, bias_cut, 1'b0, volt_temp_adc_power,
                           current_adc_power};
    wire [7:0]  off_pins = {pwr_state, 2'h0, mcu_supply_en, hp_clk_en, analog_pd, lp_osc_en};
    wire [7:0]  cont_pins = {mcu_rst_n, mcu_supply_en, mcu_clk_en, trig_timer_en, temp_ext_sel,
                             vt_meas_temp, volt_temp_adc_power, current_adc_power};
    initial forever #5 ref_clk = ~ref_clk;
    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_of_test;
        end
    end
    power_down_measurement_sequencer #(.LIN_WAKE_CYC(LWC), .SETTLE_CYC(STL)) u_dut (
        .ref_clk, .rstn, .spi_sclk, .spi_csn, .spi_mosi, .spi_miso, .lin_rxd,
        .wdog_irq(irq[0]), .sleep_timer_irq(irq[1]), .cur_adc_irq(irq[2]),
        .volt_adc_irq(irq[3]), .temp_adc_irq(irq[4]), .meas_busy, .current_adc_power,
        .volt_temp_adc_power, .temp_ext_sel, .vt_meas_temp, .trig_timer_en, .meas_abort,
        .bias_cut, .refbuf_offcancel_off, .lp_osc_en, .hp_clk_en, .mcu_supply_en,
        .mcu_clk_en, .mcu_rst_n, .analog_pd, .pwr_state);
    mcu_spi_model u_mcu (.ref_clk, .spi_miso, .spi_sclk, .spi_csn, .spi_mosi);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_st(input logic [1:0] s);
        for (int n = 0; n < 300 && pwr_state !== s; n++) @(negedge ref_clk);
        chk({6'h00, pwr_state}, {6'h00, s});
    endtask
    task automatic enter(input logic [7:0] cfg, input logic [7:0] en);
        u_mcu.xfer({1'b0, `ADDR_SLEEP_POWER_CONFIG, cfg}, q);
        u_mcu.xfer({1'b0, `ADDR_WAKE_IRQ_ENABLE, en}, q);
        u_mcu.xfer({1'b0, `ADDR_POWERDOWN_COMMAND, `CMD_ENTER_PD}, q);
    endtask
    task automatic t_regs;
        u_mcu.xfer({1'b1, `ADDR_FULL_POWER_CONFIG, 8'h00}, q);
        chk(q, `FULL_POWER_RESET);
        u_mcu.xfer({1'b0, `ADDR_FULL_POWER_CONFIG, 8'hFF}, q);
        chk(fp_pins, 8'h3B);
        u_mcu.xfer({1'b1, `ADDR_FULL_POWER_CONFIG, 8'h00}, q);
        chk(q, 8'h3F);
        u_mcu.xfer({1'b0, `ADDR_FULL_POWER_CONFIG, 8'h12}, q);
        chk(fp_pins, 8'h12);
        u_mcu.xfer({1'b0, `ADDR_FULL_POWER_CONFIG, 8'h00}, q);
        u_mcu.xfer({1'b0, `ADDR_POWERDOWN_COMMAND, 8'h55}, q);
        chk({6'h00, pwr_state}, 8'h00);
        u_mcu.xfer({1'b1, `ADDR_POWERDOWN_COMMAND, 8'h00}, q);
        chk(q, `CMD_RESET);
        u_mcu.xfer({1'b1, 7'h7E, 8'h00}, q);
        chk(q, 8'h00);
    endtask
    // continuous modes: 4 woken by current, 5 by voltage, 6 by temperature, 7 by watchdog
    task automatic t_cont;
        logic [4:0] src;
        logic [1:0] s;
        for (int i = 4; i < 8; i++) begin
            src = (i == 7) ? 5'h01 : 5'h01 << (i - 2);
            s = (i == 7) ? 2'h2 : {1'b0, i != 5};
            enter({3'h0, i[2:0], s}, {4'h0, src[4] | src[3], src[2:0]});
            wait_st((s == 2'h0) ? 2'h1 : s);
            chk(cont_pins & 8'h3F, {4'h0, i == 7, i > 5, i != 4, 1'b1});
            irq = src;
            wait_st(2'h0);
            irq = 5'h00;
            repeat (STL + 4) @(negedge ref_clk);
            chk(cont_pins, 8'hE0);
        end
    endtask
    // wake in mid-measurement of the discrete external-temperature mode
    task automatic t_abort;
        logic seen;
        enter(8'h0D, 8'h02);
        wait_st(2'h1);
        chk({7'h00, trig_timer_en}, 8'h01);
        seen = 1'b0;
        meas_busy = 1'b1;
        irq = 5'h02;
        repeat (30) begin
            @(negedge ref_clk);
            seen |= meas_abort;
        end
        chk({7'h00, seen}, 8'h01);
        wait_st(2'h0);
        irq = 5'h00;
        meas_busy = 1'b0;
    endtask
    // off state: stuck without LIN wake, then a short and a long LIN low
    task automatic t_off;
        enter(8'h03, 8'h00);
        wait_st(2'h3);
        irq = 5'h1F;
        lin_rxd = 1'b0;
        repeat (LWC + 40) @(negedge ref_clk);
        lin_rxd = 1'b1;
        irq = 5'h00;
        chk({6'h00, pwr_state}, 8'h03);
        rstn = 1'b0;
        repeat (3) @(negedge ref_clk);
        rstn = 1'b1;
        enter(8'h03, 8'h10);
        repeat (10) @(negedge ref_clk);
        chk(off_pins, 8'hC2);
        lin_rxd = 1'b0;
        repeat (LWC / 2) @(negedge ref_clk);
        chk(off_pins, 8'hC3);
        lin_rxd = 1'b1;
        repeat (20) @(negedge ref_clk);
        chk(off_pins, 8'hC2);
        lin_rxd = 1'b0;
        wait_st(2'h0);
        lin_rxd = 1'b1;
        repeat (STL + 4) @(negedge ref_clk);
        chk(cont_pins, 8'hE0);
    endtask
    task automatic end_of_test;
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // main sequence after ten reset cycles
    initial begin
        repeat (10) @(negedge ref_clk);
        rstn = 1'b1;
        t_regs;
        t_cont;
        t_abort;
        t_off;
        end_of_test;
    end
endmodule // tb_top
